// ==== status_pkg.sv ====
// status reporting package: command codes, bit positions, widths, reset values
// assumes one instrument clock; consumed by status_reporting, remote_ctl, the checker and the bench
package status_pkg;

  // standard event bit positions
  localparam int unsigned SE_OPC = 0;
  localparam int unsigned SE_RQC = 1;
  localparam int unsigned SE_QYE = 2;
  localparam int unsigned SE_DDE = 3;
  localparam int unsigned SE_EXE = 4;
  localparam int unsigned SE_CME = 5;
  localparam int unsigned SE_URQ = 6;
  localparam int unsigned SE_PON = 7;
  localparam logic [7:0] SE_ERROR_MASK = 8'h3c;

  // status byte bit positions
  localparam int unsigned SB_MESSAGE       = 4;
  localparam int unsigned SB_EVENT_SUMMARY = 5;
  localparam int unsigned SB_REQUEST       = 6;
  localparam int unsigned SB_OP_SUMMARY    = 7;

  // operation and hardware register bit positions
  localparam int unsigned OP_RUNNING    = 3;
  localparam int unsigned OP_ARMED      = 5;
  localparam int unsigned OP_OVERLOAD   = 11;
  localparam int unsigned OP_HW_SUMMARY = 12;
  localparam int unsigned HW_BATTERY    = 0;
  localparam int unsigned HW_CLOCK_LOCK = 12;

  // error queue figures
  localparam int unsigned ERR_DEPTH      = 30;
  localparam logic [9:0]  ERR_OVERFLOW   = 10'h15e; // code 350
  localparam logic [9:0]  ERR_NONE       = 10'h000;

  // reset values
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // commands from the remote controller
  typedef enum logic [3:0]
  {
    CMD_NONE        = 4'h0,
    CMD_SE_QUERY    = 4'h1,
    CMD_SE_EN_WRITE = 4'h2,
    CMD_SE_EN_QUERY = 4'h3,
    CMD_OP_QUERY    = 4'h4,
    CMD_OP_EN_WRITE = 4'h5,
    CMD_OP_COND_QRY = 4'h6,
    CMD_ARM_QUERY   = 4'h7,
    CMD_HW_EV_QUERY = 4'h8,
    CMD_HW_CND_QRY  = 4'h9,
    CMD_ERR_QUERY   = 4'ha,
    CMD_CLEAR       = 4'hb,
    CMD_SR_EN_WRITE = 4'hc,
    CMD_SERIAL_POLL = 4'hd
  } cmd_type;

  typedef struct packed
  {
    logic        valid;
    cmd_type     code;
    logic [15:0] data;
    logic        after_term; // clear arrives straight after a terminator
  } request_type;

  typedef struct packed
  {
    logic        valid;
    logic        no_error;   // error query found the queue empty
    logic [15:0] data;
  } answer_type;

  // instrument events, one-cycle pulses except the levels noted
  typedef struct packed
  {
    logic [7:0] std_events;  // pulses, one per standard event bit
    logic [9:0] err_code;
    logic       err_push;
    logic       stopped;     // level
    logic       armed;       // pulse when the trigger becomes armed
    logic       overload;    // pulse
    logic       on_battery;  // level
    logic       clock_locked;// level
  } events_type;

endpackage

// ==== status_reporting.sv ====
// status reporting: standard event, operation, arm, hardware registers and error queue
// assumes requests synchronous to ref_clk, one per cycle at most
`timescale 1ns/100ps
`default_nettype none

module status_reporting
  import status_pkg::*;
#(
  parameter int unsigned ERR_ENTRIES = status_pkg::ERR_DEPTH
)
(
  input  wire logic                      ref_clk,         // instrument clock
  input  wire logic                      rst_b,           // async reset, active low
  input  wire logic                      clk_en,          // freezes all state when low
  input  wire status_pkg::request_type   req,             // command or query
  input  wire status_pkg::events_type    ev,              // instrument events
  input  wire logic                      msg_available,   // output queue not empty
  output logic [7:0]                     status_byte,     // status byte, registered from the live summary bits
  output logic                           service_request, // request line
  output logic                           clear_out_queue, // pulse: flush output queue
  output status_pkg::answer_type         ans              // query answer
);
  import status_pkg::*;

  // fewer than two slots leaves no room beside the overflow marker
  if (ERR_ENTRIES < 2 || ERR_ENTRIES > 255)
  begin : g_depth_check
    $error("error queue depth out of range");
  end

  localparam int unsigned PW = $clog2(ERR_ENTRIES + 1);
  localparam logic [PW-1:0] LAST_SLOT = PW'(ERR_ENTRIES - 1);
  localparam logic [PW-1:0] ONE       = PW'(1);

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic take;
  logic do_clear;
  assign take     = clk_en & req.valid;
  assign do_clear = take & (req.code == CMD_CLEAR);

  // ----------------------------------------------------------------
  // standard event register and mask
  // ----------------------------------------------------------------
  logic [7:0] se_r;
  logic [7:0] se_en_r;
  logic       se_read;
  assign se_read = take & (req.code == CMD_SE_QUERY);

  // events arriving with the read survive it
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      se_r <= BYTE_ZERO;
    else if (clk_en)
    begin
      if (se_read || do_clear)
        se_r <= ev.std_events;
      else
        se_r <= se_r | ev.std_events;
    end
  end

  // mask; error bits group as SE_ERROR_MASK
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      se_en_r <= BYTE_ZERO;
    else if (take && req.code == CMD_SE_EN_WRITE)
      se_en_r <= req.data[7:0];
  end

  // ----------------------------------------------------------------
  // operation event, arm event, mask
  // ----------------------------------------------------------------
  logic [15:0] op_ev_r;
  logic [15:0] op_en_r;
  logic        arm_r;
  logic        stopped_r;
  logic [15:0] op_set;
  logic        op_read;
  logic        arm_read;
  assign op_read  = take & (req.code == CMD_OP_QUERY);
  assign arm_read = take & (req.code == CMD_ARM_QUERY);

  // stopped to running edge plus arm and overload pulses
  always_comb
  begin
    op_set = WORD_ZERO;
    op_set[OP_RUNNING]  = stopped_r & ~ev.stopped;
    op_set[OP_ARMED]    = ev.armed;
    op_set[OP_OVERLOAD] = ev.overload;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      stopped_r <= 1'b1;
    else if (clk_en)
      stopped_r <= ev.stopped;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      op_ev_r <= WORD_ZERO;
    else if (clk_en)
    begin
      if (op_read || do_clear)
        op_ev_r <= op_set;
      else
        op_ev_r <= op_ev_r | op_set;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      op_en_r <= WORD_ZERO;
    else if (take && req.code == CMD_OP_EN_WRITE)
      op_en_r <= req.data;
  end

  // sticky until query or clear; the controller must clear it per arming
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      arm_r <= 1'b0;
    else if (clk_en)
    begin
      if (arm_read || do_clear)
        arm_r <= ev.armed;
      else
        arm_r <= arm_r | ev.armed;
    end
  end

  // ----------------------------------------------------------------
  // hardware and operation condition
  // ----------------------------------------------------------------
  logic [15:0] hw_cond;
  logic [15:0] hw_ev;
  logic [15:0] op_cond;
  always_comb
  begin
    hw_cond = WORD_ZERO;
    hw_cond[HW_BATTERY]    = ev.on_battery;
    hw_cond[HW_CLOCK_LOCK] = ev.clock_locked;
    hw_ev = WORD_ZERO;
    hw_ev[HW_BATTERY]      = ev.on_battery;
    op_cond = WORD_ZERO;
    op_cond[OP_RUNNING]    = ~ev.stopped;
    op_cond[OP_ARMED]      = arm_r;
    op_cond[OP_OVERLOAD]   = op_ev_r[OP_OVERLOAD];
    op_cond[OP_HW_SUMMARY] = |hw_ev;
  end

  // ----------------------------------------------------------------
  // error queue: flip-flop ring, count includes the overflow slot
  // ----------------------------------------------------------------
  logic [9:0]    err_mem [ERR_ENTRIES];
  logic [PW-1:0] rd_ptr_r;
  logic [PW-1:0] count_r;
  logic          err_read;
  logic          err_pop;
  logic          err_wr;
  logic [PW-1:0] wr_idx;
  logic [9:0]    wr_code;
  assign err_read = take & (req.code == CMD_ERR_QUERY);
  assign err_pop  = err_read & (count_r != '0);

  function automatic logic [PW-1:0] wrap(input logic [PW:0] v);
    logic [PW:0] lim;
    lim = (PW+1)'(ERR_ENTRIES);
    wrap = (v >= lim) ? PW'(v - lim) : v[PW-1:0];
  endfunction

  // slot for a push: below the last slot, or at it with a pop, a plain error; at it without a pop the marker
  always_comb
  begin
    err_wr  = 1'b0;
    wr_idx  = wrap({1'b0, rd_ptr_r} + {1'b0, count_r});
    wr_code = ev.err_code;
    if (ev.err_push && !do_clear)
    begin
      if (count_r < LAST_SLOT || (err_pop && count_r == LAST_SLOT))
        err_wr = 1'b1;
      else if (count_r == LAST_SLOT)
      begin
        err_wr  = 1'b1;
        wr_code = ERR_OVERFLOW;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clk_en && err_wr)
      err_mem[wr_idx] <= wr_code;
  end

  // a full queue just drops further errors; last read leaves it empty
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else if (clk_en)
    begin
      if (do_clear)
      begin
        rd_ptr_r <= '0;
        count_r  <= '0;
      end
      else
      begin
        if (err_pop)
          rd_ptr_r <= wrap({1'b0, rd_ptr_r} + {1'b0, ONE});
        count_r <= count_r + (err_wr ? ONE : '0) - (err_pop ? ONE : '0);
      end
    end
  end

  // ----------------------------------------------------------------
  // status byte, service request, serial poll
  // ----------------------------------------------------------------
  logic [7:0] sr_en_r;
  logic       rqs_r;
  logic [7:0] sb_live;
  logic       poll;
  assign poll = take & (req.code == CMD_SERIAL_POLL);

  always_comb
  begin
    sb_live = BYTE_ZERO;
    sb_live[SB_MESSAGE] = msg_available;
    sb_live[SB_EVENT_SUMMARY] = |(se_r & se_en_r);
    sb_live[SB_OP_SUMMARY]    = |((op_ev_r | ({15'h0000, arm_r} << OP_ARMED)) & op_en_r);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      sr_en_r <= BYTE_ZERO;
    else if (take && req.code == CMD_SR_EN_WRITE)
      sr_en_r <= req.data[7:0];
  end

  // rises on a new enabled summary; a poll clears it, rise wins
  logic       enabled_any;
  logic       enabled_any_r;
  assign enabled_any = |(sb_live & sr_en_r & ~(8'h01 << SB_REQUEST));
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rqs_r         <= 1'b0;
      enabled_any_r <= 1'b0;
    end
    else if (clk_en)
    begin
      enabled_any_r <= enabled_any;
      if (enabled_any && !enabled_any_r)
        rqs_r <= 1'b1;
      else if (poll || do_clear)
        rqs_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_byte     <= BYTE_ZERO;
      service_request <= 1'b0;
    end
    else if (clk_en)
    begin
      status_byte     <= sb_live | ({7'h00, rqs_r} << SB_REQUEST);
      service_request <= rqs_r;
    end
  end

  // ----------------------------------------------------------------
  // answers, one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ans             <= '0;
      clear_out_queue <= 1'b0;
    end
    else if (clk_en)
    begin
      ans.valid       <= 1'b0;
      ans.no_error    <= 1'b0;
      ans.data        <= WORD_ZERO;
      clear_out_queue <= do_clear & req.after_term;
      if (take)
      begin
        unique case (req.code)
          CMD_SE_QUERY:    begin ans.valid <= 1'b1; ans.data <= {8'h00, se_r}; end
          CMD_SE_EN_QUERY: begin ans.valid <= 1'b1; ans.data <= {8'h00, se_en_r}; end
          CMD_OP_QUERY:    begin ans.valid <= 1'b1; ans.data <= op_ev_r; end
          CMD_OP_COND_QRY: begin ans.valid <= 1'b1; ans.data <= op_cond; end
          CMD_ARM_QUERY:   begin ans.valid <= 1'b1; ans.data <= {15'h0000, arm_r}; end
          CMD_HW_EV_QUERY: begin ans.valid <= 1'b1; ans.data <= hw_ev; end
          CMD_HW_CND_QRY:  begin ans.valid <= 1'b1; ans.data <= hw_cond; end
          CMD_SERIAL_POLL: begin ans.valid <= 1'b1; ans.data <= {8'h00, status_byte}; end
          CMD_ERR_QUERY:
          begin
            ans.valid    <= 1'b1;
            ans.no_error <= (count_r == '0);
            ans.data     <= (count_r == '0) ? {6'h00, ERR_NONE} : {6'h00, err_mem[rd_ptr_r]};
          end
          default:         ans.valid <= 1'b0;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== remote_ctl.sv ====
// remote controller model: commands, queries and serial polls
// assumes its tasks are called right after a falling edge
`timescale 1ns/100ps
`default_nettype none
module remote_ctl
  import status_pkg::*;
(
  input  wire logic                    ref_clk, // instrument clock
  output var  status_pkg::request_type req      // request toward the block
);
  // ----------------------------------------
  // request driving
  // ----------------------------------------
  initial req = '0;
  // valid stays up between calls so requests can run back to back
  task automatic send(input cmd_type c, input logic [15:0] d, input logic t);
    req = '{1'b1, c, d, t};
    @(negedge ref_clk);
  endtask
  // released data shows the previous data inverted
  task automatic idle;
    req = '{1'b0, req.code, ~req.data, req.after_term};
    @(negedge ref_clk);
  endtask
  // read the arm latch after each arming so the next one shows
  task automatic arm_ack;
    send(CMD_ARM_QUERY, 16'h0000, 1'b0);
    idle;
  endtask
endmodule
`default_nettype wire

// ==== status_reporting_chk.sv ====
// checker: answer timing, clear effects and echoes of the block
// bound to status_reporting; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module status_reporting_chk
  import status_pkg::*;
(
  input wire logic                    ref_clk,         // clock
  input wire logic                    rst_b,           // reset
  input wire logic                    clk_en,          // run enable
  input wire status_pkg::request_type req,             // request
  input wire status_pkg::events_type  ev,              // events
  input wire logic [7:0]              status_byte,     // status byte
  input wire logic                    clear_out_queue, // flush pulse
  input wire status_pkg::answer_type  ans              // answer
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic       taken;
  logic       is_q;
  logic       clr;
  logic       clr_t;
  logic [7:0] en_r;
  assign taken = clk_en && req.valid;
  assign is_q = taken && req.code inside {CMD_SE_QUERY, CMD_SE_EN_QUERY, CMD_OP_QUERY, CMD_OP_COND_QRY,
    CMD_ARM_QUERY, CMD_HW_EV_QUERY, CMD_HW_CND_QRY, CMD_ERR_QUERY, CMD_SERIAL_POLL};
  assign clr = taken && req.code == CMD_CLEAR && !ev.err_push;
  assign clr_t = taken && req.code == CMD_CLEAR && req.after_term;
  // shadow of the event enable mask, kept over clears
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      en_r <= 8'h00;
    else if (taken && req.code == CMD_SE_EN_WRITE)
      en_r <= req.data[7:0];
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_query_answer;
    is_q |=> ans.valid;
  endproperty
  a_query_answer: assert property (p_query_answer) else $error("query got no answer");
  property p_answer_cause;
    ans.valid && $past(clk_en) |-> $past(is_q);
  endproperty
  a_answer_cause: assert property (p_answer_cause) else $error("answer without query");
  property p_write_silent;
    taken && req.code inside {CMD_SE_EN_WRITE, CMD_OP_EN_WRITE, CMD_SR_EN_WRITE, CMD_CLEAR} |=> !ans.valid;
  endproperty
  a_write_silent: assert property (p_write_silent) else $error("write gave an answer");
  property p_outq_clear;
    clr_t |=> clear_out_queue;
  endproperty
  a_outq_clear: assert property (p_outq_clear) else $error("flush pulse missing");
  property p_outq_cause;
    clear_out_queue && $past(clk_en) |-> $past(clr_t);
  endproperty
  a_outq_cause: assert property (p_outq_cause) else $error("flush pulse without cause");
  property p_empty_zero;
    ans.valid && ans.no_error |-> ans.data == 16'h0000;
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty answer not zero");
  property p_clear_empty;
    clr ##1 (taken && req.code == CMD_ERR_QUERY && !ev.err_push) |=> ans.no_error;
  endproperty
  a_clear_empty: assert property (p_clear_empty) else $error("queue not empty after clear");
  property p_enable_echo;
    taken && req.code == CMD_SE_EN_QUERY |=> ans.data == {8'h00, en_r};
  endproperty
  a_enable_echo: assert property (p_enable_echo) else $error("enable mask echo wrong");
  property p_poll_stb;
    taken && req.code == CMD_SERIAL_POLL |=> ans.data[7:0] == $past(status_byte);
  endproperty
  a_poll_stb: assert property (p_poll_stb) else $error("poll answer not status byte");
endmodule
bind status_reporting status_reporting_chk chk (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .req(req),
  .ev(ev), .status_byte(status_byte), .clear_out_queue(clear_out_queue), .ans(ans));
`default_nettype wire

// ==== instrument_status_reporting_test.sv ====
// bench for status_reporting: events from here, requests via remote_ctl
// assumes the package, remote_ctl and the bound checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module instrument_status_reporting_test;
  import status_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        clk_en = 1'b1;
  events_type  ev;
  request_type req;
  logic [7:0]  status_byte;
  logic        service_request;
  logic        clear_out_queue;
  answer_type  ans;
  logic [16:0] exp_q[$];
  logic [9:0]  codes[31];
  logic [7:0]  r = 8'h0d;
  int          fail_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          i;
  always #5 ref_clk = ~ref_clk;
  status_reporting uut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .req(req), .ev(ev),
    .msg_available(1'b0), .status_byte(status_byte), .service_request(service_request),
    .clear_out_queue(clear_out_queue), .ans(ans));
  remote_ctl ctl (.ref_clk(ref_clk), .req(req));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string n, input logic [16:0] seen, input logic [16:0] want);
    check_count++;
    if (seen !== want)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, want, seen);
    end
  endtask
  // note first: the answer lands on the edge the send returns on
  task automatic q(input cmd_type c, input logic [16:0] e);
    exp_q.push_back(e);
    ctl.send(c, 16'h0000, 1'b0);
    ctl.idle;
  endtask
  task automatic pulse_std(input logic [7:0] b);
    ev.std_events = b;
    @(negedge ref_clk);
    ev.std_events = 8'h00;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic sb(input int b, input logic e);
    check("status bit", {16'h0000, status_byte[b]}, {16'h0000, e});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // answers are matched in order of request
  always @(negedge ref_clk)
    if (ans.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("stray answer", {ans.no_error, ans.data}, 17'h1ffff);
      else
        check("answer", {ans.no_error, ans.data}, exp_q.pop_front());
    end
  // hang guard, far above the under two hundred cycles needed
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      complete_run;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    ev = '0;
    ev.stopped = 1'b1;
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    check("status byte", {9'h000, status_byte}, 17'h00000);
    ctl.send(CMD_SE_EN_WRITE, 16'h003c, 1'b0);
    q(CMD_SE_EN_QUERY, 17'h0003c);
    for (i = 0; i < 8; i++)
    begin
      pulse_std(8'h01 << i);
      sb(5, i inside {[2:5]});
      q(CMD_SE_QUERY, 17'h00001 << i);
    end
    r = lfsr(r);
    ctl.send(CMD_SE_EN_WRITE, {8'h00, r}, 1'b0);
    ctl.idle;
    pulse_std(8'h30);
    sb(5, |(r & 8'h30));
    exp_q.push_back(17'h00030);
    ev.std_events = 8'h10;
    ctl.send(CMD_SE_QUERY, 16'h0000, 1'b0);
    ev.std_events = 8'h00;
    ctl.idle;
    q(CMD_SE_QUERY, 17'h00010);
    $display("standard event test done");
    for (i = 0; i < 31; i++)
    begin
      r = lfsr(r);
      codes[i] = {2'b00, r};
      ev.err_code = codes[i];
      ev.err_push = 1'b1;
      @(negedge ref_clk);
    end
    ev.err_push = 1'b0;
    for (i = 0; i < 31; i++)
    begin
      exp_q.push_back(i < 29 ? {7'h00, codes[i]} : i == 29 ? {7'h00, ERR_OVERFLOW} : 17'h10000);
      ctl.send(CMD_ERR_QUERY, 16'h0000, 1'b0);
    end
    ctl.idle;
    ev.err_push = 1'b1;
    ev.std_events = 8'h01;
    @(negedge ref_clk);
    ev.err_push = 1'b0;
    ev.std_events = 8'h00;
    ctl.send(CMD_CLEAR, 16'h0000, 1'b1);
    check("flush", {16'h0000, clear_out_queue}, 17'h00001);
    q(CMD_ERR_QUERY, 17'h10000);
    q(CMD_SE_QUERY, 17'h00000);
    $display("error queue test done");
    ctl.send(CMD_OP_EN_WRITE, 16'h0800, 1'b0);
    ctl.idle;
    ev.stopped = 1'b0;
    repeat (3) @(negedge ref_clk);
    sb(7, 1'b0);
    ev.overload = 1'b1;
    @(negedge ref_clk);
    ev.overload = 1'b0;
    repeat (2) @(negedge ref_clk);
    sb(7, 1'b1);
    q(CMD_OP_COND_QRY, 17'h00808);
    q(CMD_OP_QUERY, 17'h00808);
    repeat (2) @(negedge ref_clk);
    sb(7, 1'b0);
    ctl.send(CMD_OP_EN_WRITE, 16'h0020, 1'b0);
    ctl.idle;
    ev.armed = 1'b1;
    @(negedge ref_clk);
    ev.armed = 1'b0;
    repeat (6) @(negedge ref_clk);
    sb(7, 1'b1);
    exp_q.push_back(17'h00001);
    ctl.arm_ack;
    q(CMD_ARM_QUERY, 17'h00000);
    ev.on_battery = 1'b1;
    ev.clock_locked = 1'b1;
    repeat (2) @(negedge ref_clk);
    q(CMD_HW_CND_QRY, 17'h01001);
    q(CMD_HW_EV_QUERY, 17'h00001);
    $display("operation test done");
    ctl.send(CMD_SE_EN_WRITE, 16'h003c, 1'b0);
    ctl.send(CMD_SR_EN_WRITE, 16'h0020, 1'b0);
    ctl.idle;
    pulse_std(8'h04);
    repeat (2) @(negedge ref_clk);
    check("request", {16'h0000, service_request}, 17'h00001);
    q(CMD_SERIAL_POLL, 17'h000e0);
    repeat (2) @(negedge ref_clk);
    check("request", {16'h0000, service_request}, 17'h00000);
    $display("service request test done");
    // an event while the enable is low must be lost, the held bits kept
    clk_en = 1'b0;
    pulse_std(8'h01);
    clk_en = 1'b1;
    q(CMD_SE_QUERY, 17'h00004);
    $display("clock enable test done");
    repeat (3) @(negedge ref_clk);
    check("answers left", 17'(exp_q.size()), 17'h00000);
    complete_run;
  end
endmodule
`default_nettype wire
